// file: common/tph_pkg.sv
package tph_pkg;
    localparam int TPH_CLK_NS = 25;
    localparam int TPH_SAMPLE_NS = 1000000;
    localparam int TPH_TICK_CYC = (TPH_SAMPLE_NS + TPH_CLK_NS - 1) / TPH_CLK_NS;

    localparam logic [7:0] TPH_OFF_CTRL = 8'h00;
    localparam logic [7:0] TPH_OFF_CLEAR = 8'h04;
    localparam logic [7:0] TPH_OFF_TRANS = 8'h08;
    localparam logic [7:0] TPH_OFF_EMIS = 8'h0C;
    localparam logic [7:0] TPH_OFF_SWOFF = 8'h10;
    localparam logic [7:0] TPH_OFF_WARN = 8'h14;
    localparam logic [7:0] TPH_OFF_RANGE_LO = 8'h18;
    localparam logic [7:0] TPH_OFF_SUB_LO = 8'h1C;
    localparam logic [7:0] TPH_OFF_AO_GAIN = 8'h20;
    localparam logic [7:0] TPH_OFF_STATUS = 8'h24;
    localparam logic [7:0] TPH_OFF_AO = 8'h28;
    localparam logic [7:0] TPH_OFF_STRENGTH = 8'h2C;

    localparam int TPH_CTRL_SETTLE_LSB = 0;
    localparam int TPH_CTRL_MODE_LSB = 4;
    localparam int TPH_CTRL_LIVE_BIT = 8;
    localparam int TPH_CTRL_LOW21_BIT = 9;
    localparam int TPH_CTRL_MONO_BIT = 10;

    typedef enum logic [2:0] {
        TPH_CLR_OFF = 3'h0,
        TPH_CLR_TIMED = 3'h1,
        TPH_CLR_EXTERN = 3'h2,
        TPH_CLR_AUTO = 3'h3,
        TPH_CLR_HOLD = 3'h4
    } tph_clr_e;

    localparam logic [2:0] TPH_SETTLE_MIN = 3'h0;
    localparam logic [2:0] TPH_SETTLE_MAX = 3'h6;
    // Coefficients are 1-exp(-1ms/tau) in Q16, with tau the settle time over ln(10).
    localparam logic [16:0] TPH_COEF [8] = '{17'h10000, 17'h034BC, 17'h00B87, 17'h00259,
                                             17'h00097, 17'h00032, 17'h0000F, 17'h0000F};
    localparam logic [16:0] TPH_COEF_LOWSIG = 17'h07C9C;

    localparam logic [15:0] TPH_CLR_MIN = 16'h000A;
    localparam logic [15:0] TPH_CLR_MAX = 16'h61A8;
    localparam logic [15:0] TPH_CLR_RST = 16'h03E8;
    localparam logic [9:0] TPH_PM_FULL = 10'h3E8;
    localparam logic [9:0] TPH_TRANS_MIN = 10'h032;
    localparam logic [5:0] TPH_SWOFF_MIN = 6'h02;
    localparam logic [5:0] TPH_SWOFF_MAX = 6'h32;
    localparam logic [5:0] TPH_SWOFF_RST = 6'h0A;
    localparam logic [6:0] TPH_WARN_MAX = 7'h63;
    localparam logic [29:0] TPH_PCT_SCALE = 30'h00989680;
    localparam logic [15:0] TPH_AUTO_ABS = 16'h0002;
    localparam logic [15:0] TPH_AUTO_DIV = 16'h0064;
    localparam logic [15:0] TPH_AO_ZERO = 16'h0000;
    localparam logic [15:0] TPH_AO_LIVE = 16'h0FA0;
    localparam logic [15:0] TPH_AO_TOP = 16'h4E20;
    localparam logic [15:0] TPH_AO_UNDER = 16'h0F3C;
    localparam logic [15:0] TPH_AO_LOW = 16'h5208;
    localparam logic [15:0] TPH_GAIN_RST = 16'h0100;
endpackage

// file: common/tph_chain_if.sv
`timescale 1ns/1ps
interface tph_chain_if
    import tph_pkg::*;
();
    logic tick;
    logic low_sig;
    logic contact;
    logic [2:0] settle;
    logic [15:0] raw;
    logic [15:0] filt;
    logic [15:0] clr_ms;
    logic [15:0] sub_lo;
    logic [15:0] peak;
    tph_clr_e mode;
    modport filt_mp (input tick, raw, low_sig, settle, output filt);
    modport peak_mp (input tick, filt, mode, clr_ms, sub_lo, contact, output peak);
    modport top_mp (output tick, raw, low_sig, settle, mode, clr_ms, sub_lo, contact,
                    input peak);
endinterface

// file: rtl/tph_filter.sv
`timescale 1ns/1ps
module tph_filter
    import tph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    tph_chain_if.filt_mp ch
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [16:0] coef;
    logic signed [33:0] diff;
    logic signed [51:0] prod;

    // A weak signal in the min setting slows the filter so noise stays off the output.
    assign coef = (ch.settle == TPH_SETTLE_MIN && ch.low_sig) ? TPH_COEF_LOWSIG
                                                                : TPH_COEF[ch.settle];
    assign diff = $signed({2'b00, ch.raw, 16'h0000}) - $signed({2'b00, acc_r});
    assign prod = diff * $signed({1'b0, coef});
    assign acc_nxt = acc_r + prod[47:16];
    assign ch.filt = ch.tick ? acc_nxt[31:16] : acc_r[31:16];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_r <= '0;
        end else if (ch.tick) begin
            acc_r <= acc_nxt;
        end
    end

    a_min_passes: assert property (@(posedge clk_sys) disable iff (reset)
        ch.tick && ch.settle == TPH_SETTLE_MIN && !ch.low_sig |-> ch.filt == ch.raw)
        else $error("Min setting did not pass the sample through.");
endmodule

// file: rtl/tph_peak.sv
`timescale 1ns/1ps
module tph_peak
    import tph_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    tph_chain_if.peak_mp ch
);
    logic [15:0] mem_r [2];
    logic [15:0] mem_nxt [2];
    logic [15:0] peak_r;
    logic [15:0] peak_nxt;
    logic [15:0] shown;
    logic [15:0] cnt_r;
    logic [15:0] margin;
    logic [16:0] thr;
    logic sel_r;
    logic armed_r;
    logic pend_r;
    logic contact_q;
    logic closure;
    logic ext_clr;
    logic auto_clr;
    logic iv_end;
    logic restart;
    tph_clr_e mode_q;

    assign closure = ch.contact && !contact_q;
    assign ext_clr = ch.mode == TPH_CLR_EXTERN && (pend_r || closure);
    assign margin = (ch.sub_lo / TPH_AUTO_DIV > TPH_AUTO_ABS) ? ch.sub_lo / TPH_AUTO_DIV
                                                              : TPH_AUTO_ABS;
    assign thr = {1'b0, ch.sub_lo} + {1'b0, margin};
    assign auto_clr = ch.mode == TPH_CLR_AUTO && armed_r && {1'b0, ch.filt} > thr;
    assign iv_end = ch.mode == TPH_CLR_TIMED && cnt_r >= ch.clr_ms - 16'h0001;
    assign restart = ch.mode != mode_q;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_mem
            logic wipe;
            // The memory not cleared last time is wiped, so the two alternate.
            assign wipe = restart || ext_clr || auto_clr || (iv_end && sel_r != 1'(i));
            assign mem_nxt[i] = (wipe || ch.filt > mem_r[i]) ? ch.filt : mem_r[i];
        end
    endgenerate

    assign shown = iv_end ? mem_nxt[sel_r] : mem_nxt[!sel_r];
    assign peak_nxt = (ch.mode == TPH_CLR_TIMED) ? shown :
                      (ch.mode == TPH_CLR_EXTERN || ch.mode == TPH_CLR_AUTO) ? mem_nxt[0] :
                      (ch.mode == TPH_CLR_HOLD && ch.contact) ? peak_r : ch.filt;
    assign ch.peak = peak_r;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            contact_q <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            contact_q <= ch.contact;
            // A closure between samples waits for the next one instead of being lost.
            pend_r <= (closure || pend_r) && !ch.tick;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mem_r <= '{16'h0000, 16'h0000};
            peak_r <= 16'h0000;
            mode_q <= TPH_CLR_OFF;
            sel_r <= 1'b0;
            cnt_r <= 16'h0000;
            armed_r <= 1'b0;
        end else if (ch.tick) begin
            mem_r <= mem_nxt;
            peak_r <= peak_nxt;
            mode_q <= ch.mode;
            sel_r <= sel_r ^ iv_end;
            cnt_r <= (iv_end || restart || ch.mode != TPH_CLR_TIMED) ? 16'h0000 : cnt_r + 16'h0001;
            armed_r <= (ch.filt <= ch.sub_lo) ? 1'b1 : (auto_clr ? 1'b0 : armed_r);
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_iv_end;
        ch.tick && iv_end && !restart;
    endsequence

    a_off_passes: assert property (
        ch.tick && ch.mode == TPH_CLR_OFF |=> ch.peak == $past(ch.filt))
        else $error("Off setting held a value.");
    a_hold_freezes: assert property (
        ch.tick && ch.mode == TPH_CLR_HOLD && ch.contact && !restart |=> $stable(ch.peak))
        else $error("Hold reading moved while contact closed.");
    a_ext_clears: assert property (
        ch.tick && ext_clr && !restart |=> ch.peak == $past(ch.filt))
        else $error("External clear did not restart the peak.");
    a_peak_keeps: assert property (
        ch.tick && ch.mode == TPH_CLR_EXTERN && !ext_clr && !restart
        |=> ch.peak >= $past(ch.peak))
        else $error("Stored peak dropped without a clear.");
    a_auto_clears: assert property (
        ch.tick && auto_clr && !restart |=> ch.peak == $past(ch.filt) && !armed_r)
        else $error("Automatic clear did not take the new object.");
    a_timed_swaps: assert property (
        s_iv_end |=> sel_r != $past(sel_r) && cnt_r == 16'h0000)
        else $error("Interval end did not swap memories.");
endmodule

// file: rtl/tph_top.sv
`timescale 1ns/1ps
// How it works
// - Transmittance accepted from 5% to 100% per mille, used in single-wavelength mode.
// - A new measurement every millisecond updates the analog output.
// - Settle choices: min below 2 ms, adapting at low signal, or 10 ms to 10 s.
// - Filter coefficients make the settle time the 90% step response time.
// - The smoothing runs first and feeds the peak memory.
// - Peak storage is on in every clear mode except off and hold.
// - Off mode passes each new value through unheld.
// - Timed mode runs two memories, cleared alternately, showing the older one.
// - External mode clears its single memory on each contact closure.
// - Automatic mode holds one memory until a new hot object appears.
// - Automatic clear when above sub-range low by 1% or at least 2 degrees.
// - Hold mode freezes the reading while the contact stays closed.
// - Live-zero range drives 3.9 mA below the lower limit.
// - Zero or live-zero ranges; low-signal option drives 21 mA on weak signal.
// - Warning threshold 0 to 99% switches the relay on weak radiation.
// - Zero threshold disables warning and hands the contact to external clear.
// - Signal strength is emissivity times coverage, times transmission only in single-wavelength mode.
// - Weak signal reports one degree below the range start.
// - Switch-off level accepted from 2% to 50%, default 10%.
module tph_top
    import tph_pkg::*;
#(
    parameter int TICK_CYC = TPH_TICK_CYC
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [15:0] meas_temp,
    input wire logic [9:0] meas_cover,
    input wire logic contact_in,
    output logic [15:0] disp_temp,
    output logic [15:0] ao_ua,
    output logic relay_warn
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    tph_chain_if ch ();

    tph_filter u_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .ch(ch.filt_mp)
    );

    tph_peak u_peak (
        .clk_sys(clk_sys),
        .reset(reset),
        .ch(ch.peak_mp)
    );

    logic [15:0] tick_cnt_r;
    logic tick_r;
    logic tick_d_r;
    logic [2:0] sync_r;
    logic contact_r;
    logic [2:0] settle_r;
    tph_clr_e mode_r;
    logic live_r;
    logic low21_r;
    logic mono_r;
    logic [15:0] clr_ms_r;
    logic [9:0] trans_r;
    logic [9:0] emis_r;
    logic [5:0] swoff_r;
    logic [6:0] warn_r;
    logic [15:0] range_lo_r;
    logic [15:0] sub_lo_r;
    logic [15:0] ao_gain_r;
    logic low_r;
    logic relay_r;
    logic [15:0] disp_r;
    logic [15:0] ao_r;
    logic [31:0] rdata_r;

    logic wr_ctrl;
    logic [2:0] wr_settle;
    logic [2:0] wr_mode;
    logic [9:0] wr_pm;
    logic [15:0] wr_half;
    logic [9:0] trans_eff;
    logic [19:0] et;
    logic [29:0] strength;
    logic [29:0] swoff_lim;
    logic [29:0] warn_lim;
    logic low_sig;
    logic warn_now;
    logic below;
    logic [15:0] delta;
    logic [31:0] scaled;
    logic [15:0] base;
    logic [24:0] lin;
    logic [15:0] ao_lin;
    logic [15:0] ao_nxt;
    logic [31:0] rd_val;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
            tick_d_r <= 1'b0;
        end else begin
            tick_cnt_r <= (tick_cnt_r == 16'(TICK_CYC - 1)) ? 16'h0000 : tick_cnt_r + 16'h0001;
            tick_r <= tick_cnt_r == 16'(TICK_CYC - 1);
            tick_d_r <= tick_r;
        end
    end

    // The contact bounces, so a level is taken only once two stages agree.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_r <= 3'h0;
            contact_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], contact_in};
            contact_r <= (sync_r[2] == sync_r[1]) ? sync_r[2] : contact_r;
        end
    end

    assign wr_ctrl = bus_wr && hit(bus_addr, TPH_OFF_CTRL);
    assign wr_settle = bus_wdata[TPH_CTRL_SETTLE_LSB +: 3];
    assign wr_mode = bus_wdata[TPH_CTRL_MODE_LSB +: 3];
    assign wr_pm = bus_wdata[9:0];
    assign wr_half = bus_wdata[15:0];

    // Out-of-range settings are ignored so the block never runs on an illegal value.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            settle_r <= TPH_SETTLE_MIN;
            mode_r <= TPH_CLR_OFF;
            live_r <= 1'b0;
            low21_r <= 1'b0;
            mono_r <= 1'b0;
            clr_ms_r <= TPH_CLR_RST;
            trans_r <= TPH_PM_FULL;
            emis_r <= TPH_PM_FULL;
            swoff_r <= TPH_SWOFF_RST;
            warn_r <= 7'h00;
            range_lo_r <= 16'h0000;
            sub_lo_r <= 16'h0000;
            ao_gain_r <= TPH_GAIN_RST;
        end else if (bus_wr) begin
            if (wr_ctrl && wr_settle <= TPH_SETTLE_MAX) begin
                settle_r <= wr_settle;
            end
            if (wr_ctrl && wr_mode <= TPH_CLR_HOLD) begin
                mode_r <= tph_clr_e'(wr_mode);
            end
            if (wr_ctrl) begin
                live_r <= bus_wdata[TPH_CTRL_LIVE_BIT];
                low21_r <= bus_wdata[TPH_CTRL_LOW21_BIT];
                mono_r <= bus_wdata[TPH_CTRL_MONO_BIT];
            end
            if (hit(bus_addr, TPH_OFF_CLEAR) && wr_half >= TPH_CLR_MIN
                && wr_half <= TPH_CLR_MAX) begin
                clr_ms_r <= wr_half;
            end
            if (hit(bus_addr, TPH_OFF_TRANS) && wr_pm >= TPH_TRANS_MIN
                && wr_pm <= TPH_PM_FULL) begin
                trans_r <= wr_pm;
            end
            if (hit(bus_addr, TPH_OFF_EMIS) && wr_pm <= TPH_PM_FULL) begin
                emis_r <= wr_pm;
            end
            if (hit(bus_addr, TPH_OFF_SWOFF) && bus_wdata[5:0] >= TPH_SWOFF_MIN
                && bus_wdata[5:0] <= TPH_SWOFF_MAX) begin
                swoff_r <= bus_wdata[5:0];
            end
            if (hit(bus_addr, TPH_OFF_WARN) && bus_wdata[6:0] <= TPH_WARN_MAX) begin
                warn_r <= bus_wdata[6:0];
            end
            if (hit(bus_addr, TPH_OFF_RANGE_LO)) begin
                range_lo_r <= wr_half;
            end
            if (hit(bus_addr, TPH_OFF_SUB_LO)) begin
                sub_lo_r <= wr_half;
            end
            if (hit(bus_addr, TPH_OFF_AO_GAIN)) begin
                ao_gain_r <= wr_half;
            end
        end
    end

    assign trans_eff = mono_r ? trans_r : TPH_PM_FULL;
    assign et = emis_r * trans_eff;
    assign strength = et * meas_cover;
    assign swoff_lim = swoff_r * TPH_PCT_SCALE;
    assign warn_lim = warn_r * TPH_PCT_SCALE;
    assign low_sig = strength < swoff_lim;
    assign warn_now = warn_r != 7'h00 && strength < warn_lim;

    assign ch.tick = tick_r;
    assign ch.low_sig = low_sig;
    assign ch.raw = low_sig ? range_lo_r - 16'h0001 : meas_temp;
    assign ch.settle = settle_r;
    assign ch.mode = mode_r;
    assign ch.clr_ms = clr_ms_r;
    assign ch.sub_lo = sub_lo_r;
    assign ch.contact = contact_r && warn_r == 7'h00;

    assign below = ch.peak < sub_lo_r;
    assign delta = ch.peak - sub_lo_r;
    assign scaled = delta * ao_gain_r;
    assign base = live_r ? TPH_AO_LIVE : TPH_AO_ZERO;
    assign lin = {9'h000, base} + {1'b0, scaled[31:8]};
    assign ao_lin = (lin > {9'h000, TPH_AO_TOP}) ? TPH_AO_TOP : lin[15:0];
    // The output stage runs one cycle behind the peak so display and current show one sample.
    assign ao_nxt = (low21_r && low_r) ? TPH_AO_LOW :
                    !below ? ao_lin :
                    live_r ? TPH_AO_UNDER : TPH_AO_ZERO;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            low_r <= 1'b0;
            relay_r <= 1'b0;
            disp_r <= 16'h0000;
            ao_r <= TPH_AO_ZERO;
        end else begin
            if (tick_r) begin
                low_r <= low_sig;
                relay_r <= warn_now;
            end
            if (tick_d_r) begin
                disp_r <= ch.peak;
                ao_r <= ao_nxt;
            end
        end
    end

    assign rd_val = hit(bus_addr, TPH_OFF_CTRL) ? {21'h000000, mono_r, low21_r, live_r, 1'b0,
                                                   mode_r, 1'b0, settle_r} :
                    hit(bus_addr, TPH_OFF_CLEAR) ? {16'h0000, clr_ms_r} :
                    hit(bus_addr, TPH_OFF_TRANS) ? {22'h000000, trans_r} :
                    hit(bus_addr, TPH_OFF_EMIS) ? {22'h000000, emis_r} :
                    hit(bus_addr, TPH_OFF_SWOFF) ? {26'h0000000, swoff_r} :
                    hit(bus_addr, TPH_OFF_WARN) ? {25'h0000000, warn_r} :
                    hit(bus_addr, TPH_OFF_RANGE_LO) ? {16'h0000, range_lo_r} :
                    hit(bus_addr, TPH_OFF_SUB_LO) ? {16'h0000, sub_lo_r} :
                    hit(bus_addr, TPH_OFF_AO_GAIN) ? {16'h0000, ao_gain_r} :
                    hit(bus_addr, TPH_OFF_STATUS) ? {13'h0000, contact_r, relay_r, low_r, disp_r} :
                    hit(bus_addr, TPH_OFF_AO) ? {16'h0000, ao_r} :
                    hit(bus_addr, TPH_OFF_STRENGTH) ? {2'b00, strength} : 32'h00000000;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= bus_rd ? rd_val : 32'h00000000;
        end
    end

    assign bus_rdata = rdata_r;
    assign disp_temp = disp_r;
    assign ao_ua = ao_r;
    assign relay_warn = relay_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_ao_on_sample: assert property (
        $changed(ao_r) |-> $past(tick_d_r))
        else $error("Analog output changed outside a sample.");
    a_low_report: assert property (
        tick_r && low_sig |-> ch.raw == range_lo_r - 16'h0001)
        else $error("Weak signal not reported below range start.");
    a_under_code: assert property (
        tick_d_r && live_r && !(low21_r && low_r) && below |=> ao_r == TPH_AO_UNDER)
        else $error("Below-range code missing.");
    a_low_code: assert property (
        tick_d_r && low21_r && low_r |=> ao_r == TPH_AO_LOW)
        else $error("Low-signal code missing.");
    a_relay_warn: assert property (
        tick_r |=> relay_r == $past(warn_now))
        else $error("Relay does not follow the warning level.");
    a_contact_gate: assert property (
        warn_r != 7'h00 |-> !ch.contact)
        else $error("Contact clears peak while warning is on.");
    a_trans_range: assert property (
        trans_r >= TPH_TRANS_MIN && trans_r <= TPH_PM_FULL)
        else $error("Transmittance out of range.");
    a_swoff_range: assert property (
        swoff_r >= TPH_SWOFF_MIN && swoff_r <= TPH_SWOFF_MAX)
        else $error("Switch-off level out of range.");
    a_disp_on_sample: assert property (
        tick_d_r |=> disp_r == $past(ch.peak))
        else $error("Display missed the new sample.");
    a_low_latched: assert property (
        tick_r |=> low_r == $past(low_sig))
        else $error("Low-signal flag did not follow the sample.");
endmodule

// file: testbench/tph_relay_model.sv
`timescale 1ns/1ps
// External relay contact; LAG models a slow armature, so closure reaches the pin late.
module tph_relay_model #(
    parameter int LAG = 2
)
(
    input wire logic clk_sys,
    input wire logic close_cmd,
    output logic contact_in
);
    logic [7:0] pipe_r = 8'h00;
    wire logic [8:0] taps = {pipe_r, close_cmd};
    always_ff @(posedge clk_sys) begin
        pipe_r <= {pipe_r[6:0], close_cmd};
    end
    assign contact_in = taps[LAG];
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tph_pkg::*;
    // A short sample period keeps the run small; settling waits are counted in samples, bus accesses in clock cycles.
    localparam int TICK = 20;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h00000000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [15:0] meas_temp = 16'h0000;
    logic [9:0] meas_cover = 10'h3E8;
    logic close_cmd = 1'b0;
    logic contact_in;
    logic [15:0] disp_temp;
    logic [15:0] ao_ua;
    logic relay_warn;
    int mismatches = 0;
    int checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    tph_top #(.TICK_CYC(TICK)) u_tph_top (.clk_sys(clk_sys), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .meas_temp(meas_temp), .meas_cover(meas_cover),
        .contact_in(contact_in), .disp_temp(disp_temp), .ao_ua(ao_ua),
        .relay_warn(relay_warn));
    tph_relay_model #(.LAG(2)) u_tph_relay_model (.clk_sys(clk_sys),
        .close_cmd(close_cmd), .contact_in(contact_in));

    task automatic end_of_test();
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(n, e, bus_rdata);
    endtask

    task automatic wait_ticks(input int n);
        repeat (n * TICK) @(posedge clk_sys);
        #1;
    endtask

    task automatic set_temp(input logic [15:0] v);
        @(posedge clk_sys);
        meas_temp <= v;
        wait_ticks(3);
    endtask

    task automatic press(input logic v);
        @(posedge clk_sys);
        close_cmd <= v;
        wait_ticks(2);
    endtask

    task automatic test_regs();
        chk("rdata idle", 32'h00000000, bus_rdata);
        rd_chk(TPH_OFF_CLEAR, 32'h000003E8, "clear reset");
        rd_chk(TPH_OFF_SWOFF, 32'h0000000A, "swoff reset");
        rd_chk(TPH_OFF_WARN, 32'h00000000, "warn reset");
        wr(TPH_OFF_CTRL, 32'h00000007);
        rd_chk(TPH_OFF_CTRL, 32'h00000000, "settle refused");
        wr(TPH_OFF_CLEAR, 32'h00000005);
        rd_chk(TPH_OFF_CLEAR, 32'h000003E8, "clear refused");
        wr(TPH_OFF_CLEAR, 32'h000061A8);
        rd_chk(TPH_OFF_CLEAR, 32'h000061A8, "clear top");
        wr(TPH_OFF_TRANS, 32'h00000031);
        rd_chk(TPH_OFF_TRANS, 32'h000003E8, "trans refused");
        wr(TPH_OFF_SWOFF, 32'h00000033);
        rd_chk(TPH_OFF_SWOFF, 32'h0000000A, "swoff refused");
        wr(TPH_OFF_EMIS, 32'h00000258);
        wr(TPH_OFF_TRANS, 32'h00000384);
        wr(TPH_OFF_CTRL, 32'h00000400);
        rd_chk(TPH_OFF_STRENGTH, 32'h202FBF00, "mono strength");
        rd_chk(8'h30, 32'h00000000, "unmapped");
    endtask

    task automatic test_off();
        set_temp(16'h01F4);
        chk("off disp", 32'h000001F4, {16'h0000, disp_temp});
        chk("off ao", 32'h000001F4, {16'h0000, ao_ua});
        set_temp(16'h7530);
        chk("ao clamp", {16'h0000, TPH_AO_TOP}, {16'h0000, ao_ua});
    endtask

    task automatic test_extern();
        set_temp(16'h0064);
        wr(TPH_OFF_CTRL, 32'h00000020);
        set_temp(16'h0384);
        set_temp(16'h02BC);
        chk("peak held", 32'h00000384, {16'h0000, disp_temp});
        press(1'b1);
        chk("ext clear", 32'h000002BC, {16'h0000, disp_temp});
        press(1'b0);
    endtask

    task automatic test_hold();
        wr(TPH_OFF_CTRL, 32'h00000040);
        set_temp(16'h028A);
        press(1'b1);
        set_temp(16'h0258);
        chk("frozen", 32'h0000028A, {16'h0000, disp_temp});
        press(1'b0);
        chk("released", 32'h00000258, {16'h0000, disp_temp});
    endtask

    task automatic test_auto();
        wr(TPH_OFF_SUB_LO, 32'h00000258);
        wr(TPH_OFF_CTRL, 32'h00000030);
        set_temp(16'h0384);
        set_temp(16'h01F4);
        chk("auto held", 32'h00000384, {16'h0000, disp_temp});
        set_temp(16'h025D);
        chk("auto margin", 32'h00000384, {16'h0000, disp_temp});
        set_temp(16'h025F);
        chk("auto clear", 32'h0000025F, {16'h0000, disp_temp});
    endtask

    task automatic test_timed();
        wr(TPH_OFF_CLEAR, 32'h0000000A);
        wr(TPH_OFF_CTRL, 32'h00000010);
        set_temp(16'h0384);
        set_temp(16'h012C);
        chk("timed keeps", 32'h00000384, {16'h0000, disp_temp});
        wait_ticks(25);
        chk("timed swap", 32'h0000012C, {16'h0000, disp_temp});
    endtask

    // A 10 ms setting must sit below 90% of the step after 9 samples and above it after 12.
    task automatic test_settle();
        wr(TPH_OFF_CTRL, 32'h00000001);
        @(posedge clk_sys);
        meas_temp <= 16'h0514;
        wait_ticks(9);
        chk("settle early", 32'h00000001,
            {31'h0, disp_temp > 16'h012C && disp_temp < 16'h04B0});
        wait_ticks(3);
        chk("settle reached", 32'h00000001, {31'h0, disp_temp >= 16'h04B0});
    endtask

    task automatic test_analog();
        wr(TPH_OFF_CTRL, 32'h00000100);
        wr(TPH_OFF_SUB_LO, 32'h00000258);
        set_temp(16'h01F4);
        chk("below range", {16'h0000, TPH_AO_UNDER}, {16'h0000, ao_ua});
        set_temp(16'h02BC);
        chk("live span", {16'h0000, TPH_AO_LIVE + 16'h0064}, {16'h0000, ao_ua});
        wr(TPH_OFF_CTRL, 32'h00000200);
        wr(TPH_OFF_WARN, 32'h00000032);
        @(posedge clk_sys);
        meas_cover <= 10'h000;
        wait_ticks(3);
        chk("low signal ao", {16'h0000, TPH_AO_LOW}, {16'h0000, ao_ua});
        chk("relay warn", 32'h00000001, {31'h0, relay_warn});
        rd_chk(TPH_OFF_STRENGTH, 32'h00000000, "strength");
        wr(TPH_OFF_WARN, 32'h00000000);
        wait_ticks(2);
        chk("relay off", 32'h00000000, {31'h0, relay_warn});
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        test_regs();
        test_off();
        test_extern();
        test_hold();
        test_auto();
        test_timed();
        test_settle();
        test_analog();
        end_of_test();
    end

    // A hang anywhere is cut short here and reported as a mismatch.
    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
endmodule
